// ### rtl/cbt_map.vh
// Purpose: register offsets, field positions and reset values for the can bit timing block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   included by cbt_top.v
`ifndef CBT_MAP_VH
`define CBT_MAP_VH

`define CBT_OFS_PRESCALER   8'h00
`define CBT_OFS_BIT_TIMING  8'h04
`define CBT_OFS_MAIN_CTRL   8'h08
`define CBT_OFS_GLOBAL_CTRL 8'h0C
`define CBT_OFS_IRQ_EN      8'h10
`define CBT_OFS_ACC_MASK    8'h14
`define CBT_OFS_ERR_CNT     8'h18
`define CBT_OFS_ERR_INFO    8'h1C
`define CBT_OFS_STATUS      8'h20
`define CBT_OFS_BUF_CTRL    8'h40
`define CBT_OFS_BUF_CONF    8'h80

`define CBT_PH1_LSB         0
`define CBT_PH1_MSB         3
`define CBT_PH2_LSB         8
`define CBT_PH2_MSB         10
`define CBT_PH1_MIN         4'h3
`define CBT_BT_MIN          5'h08
`define CBT_BT_MAX          5'h19

`define CBT_MODE_INIT       3'h0
`define CBT_MODE_NORMAL     3'h1
`define CBT_MODE_NORMAL_ABT 3'h2
`define CBT_MODE_RX_ONLY    3'h3
`define CBT_MODE_SINGLE     3'h4
`define CBT_MODE_SELF_TEST  3'h5

`define CBT_BTYPE_TX        3'h0
`define CBT_BTYPE_RX_LO     3'h1
`define CBT_BTYPE_RX_HI     3'h5

`define CBT_RDY_BIT         0
`define CBT_TRQ_BIT         1
`define CBT_DN_BIT          2
`define CBT_ASSIGNED_BIT    0
`define CBT_BTYPE_LSB       3
`define CBT_BTYPE_MSB       5
`define CBT_GC_TRIG_BIT     0
`define CBT_GC_ERRCLR_BIT   1
`define CBT_ABT_LAST_BUF    4'h7

`define CBT_RST_BIT_TIMING  32'h0000_0603

`endif

// ### rtl/cbt_top.v
// Purpose: can bit timing, mode control and message buffer control registers
// Assumes: classic wishbone slave, ack one cycle after request, 100 MHz clock
// Notes:   the bit engine itself is outside; this block gives tq and bit pulses
// Overview of operation
// - time quantum is clock over prescaler plus one
// - bit is sync plus phase one plus two
// - bit rate is clock over prescale times quanta
// - mode field selects one of six modes
// - type 000 transmit, 001 to 101 receive
// - block transmission covers only buffers 0-7
// - bit time spans 6 to 25 quanta
// - phase one 4-16, phase two 1-8 quanta
// - phase one bits 0-3, phase two bits 8-10
`timescale 1ns/1ps
`default_nettype none
`include "cbt_map.vh"
module cbt_top (
	// system
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// bit timing toward the protocol engine
	output reg         tq_tick_o,
	output reg         bit_tick_o,
	output reg         sample_pt_o,
	// status from the protocol engine
	input  wire        tx_busy_i,
	input  wire        tx_done_i,
	// transmit request and operating mode toward the protocol engine
	output reg         tx_start_o,
	output reg  [3:0]  tx_buf_o,
	output reg  [2:0]  mode_o
);
	reg [7:0]  prescaler_r;
	reg [31:0] bit_timing_reg_r;
	reg [2:0]  operating_mode_r;
	reg        block_tx_trigger_r;
	reg [15:0] irq_enable_r;
	reg [31:0] acceptance_mask_r;
	reg [7:0]  error_counter_r;
	reg [7:0]  error_info_r;
	reg [2:0]  buf_ctrl_r [0:15];
	reg [3:0]  buf_conf_r [0:15];
	reg [7:0]  pre_cnt_r;
	reg [4:0]  tq_cnt_r;
	reg [3:0]  abt_ptr_r;
	reg        tx_pending_r;
	reg [1:0]  busy_sync_r;
	reg        busy_r;
	reg        busy_s3_r;
	wire       wr;
	wire       rd;
	wire [3:0] ph1;
	wire [2:0] ph2;
	wire [4:0] bit_len;
	wire       in_init;
	integer    i;

	// quanta per bit: ph1 field+1 plus ph2 field+1 plus sync
	function [4:0] bt_quanta;
		input [3:0] p1;
		input [2:0] p2;
		begin
			bt_quanta = {1'b0, p1} + {2'b00, p2} + 5'h03;
		end
	endfunction

	function is_rx_type;
		input [2:0] t;
		begin
			is_rx_type = (t >= `CBT_BTYPE_RX_LO) && (t <= `CBT_BTYPE_RX_HI);
		end
	endfunction

	assign wr      = cyc_i && stb_i && we_i && !ack_o;
	assign rd      = cyc_i && stb_i && !we_i && !ack_o;
	assign ph1     = bit_timing_reg_r[`CBT_PH1_MSB:`CBT_PH1_LSB];
	assign ph2     = bit_timing_reg_r[`CBT_PH2_MSB:`CBT_PH2_LSB];
	assign bit_len = bt_quanta(ph1, ph2);
	assign in_init = (operating_mode_r == `CBT_MODE_INIT);

	// timing only runs outside init, so reprogramming never glitches a live bit
	always @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt_r   <= 8'h00;
			tq_cnt_r    <= 5'h00;
			tq_tick_o   <= 1'b0;
			bit_tick_o  <= 1'b0;
			sample_pt_o <= 1'b0;
		end else begin
			tq_tick_o   <= 1'b0;
			bit_tick_o  <= 1'b0;
			sample_pt_o <= 1'b0;
			if (in_init) begin
				pre_cnt_r <= 8'h00;
				tq_cnt_r  <= 5'h00;
			end else if (pre_cnt_r == prescaler_r) begin
				pre_cnt_r <= 8'h00;
				tq_tick_o <= 1'b1;
				if (tq_cnt_r == bit_len - 5'h01) begin
					tq_cnt_r   <= 5'h00;
					bit_tick_o <= 1'b1;
				end else begin
					tq_cnt_r <= tq_cnt_r + 5'h01;
				end
				if (tq_cnt_r == {1'b0, ph1} + 5'h01)
					sample_pt_o <= 1'b1;
			end else begin
				pre_cnt_r <= pre_cnt_r + 8'h01;
			end
		end
	end

	// register writes, block transmit sequencing
	always @(posedge clk_i) begin
		if (rst_i) begin
			prescaler_r        <= 8'h00;
			bit_timing_reg_r   <= `CBT_RST_BIT_TIMING;
			operating_mode_r   <= `CBT_MODE_INIT;
			block_tx_trigger_r <= 1'b0;
			irq_enable_r       <= 16'h0000;
			acceptance_mask_r  <= 32'h0000_0000;
			error_counter_r    <= 8'h00;
			error_info_r       <= 8'h00;
			abt_ptr_r          <= 4'h0;
			tx_pending_r       <= 1'b0;
			tx_start_o         <= 1'b0;
			tx_buf_o           <= 4'h0;
			mode_o             <= `CBT_MODE_INIT;
			for (i = 0; i < 16; i = i + 1) begin
				buf_ctrl_r[i] <= 3'h0;
				buf_conf_r[i] <= 4'h0;
			end
		end else begin
			tx_start_o <= 1'b0;
			mode_o     <= operating_mode_r;
			if (wr && sel_i[0]) begin
				case (adr_i)
				`CBT_OFS_PRESCALER: begin
					if (in_init)
						prescaler_r <= dat_i[7:0];
				end
				`CBT_OFS_BIT_TIMING: begin
					// phase one below its least code is clamped, keeping bit time within range
					if (in_init) begin
						bit_timing_reg_r[3:0]  <= (dat_i[3:0] < `CBT_PH1_MIN) ? `CBT_PH1_MIN : dat_i[3:0];
						bit_timing_reg_r[10:8] <= dat_i[10:8];
					end
				end
				`CBT_OFS_MAIN_CTRL: begin
					if (dat_i[2:0] <= `CBT_MODE_SELF_TEST)
						operating_mode_r <= dat_i[2:0];
				end
				`CBT_OFS_GLOBAL_CTRL: begin
					if (operating_mode_r == `CBT_MODE_NORMAL_ABT)
						block_tx_trigger_r <= dat_i[`CBT_GC_TRIG_BIT];
					if (dat_i[`CBT_GC_ERRCLR_BIT] && in_init) begin
						error_counter_r <= 8'h00;
						error_info_r    <= 8'h00;
					end
				end
				`CBT_OFS_IRQ_EN:   irq_enable_r <= dat_i[15:0];
				`CBT_OFS_ACC_MASK: acceptance_mask_r <= dat_i;
				default: begin
					if (adr_i[7:6] == 2'b01 && adr_i[1:0] == 2'b00) begin
						// transmit request is refused unless ready already set
						buf_ctrl_r[adr_i[5:2]][`CBT_RDY_BIT] <= dat_i[`CBT_RDY_BIT];
						buf_ctrl_r[adr_i[5:2]][`CBT_TRQ_BIT] <= dat_i[`CBT_TRQ_BIT] &&
							buf_ctrl_r[adr_i[5:2]][`CBT_RDY_BIT];
						buf_ctrl_r[adr_i[5:2]][`CBT_DN_BIT]  <= dat_i[`CBT_DN_BIT];
					end else if (adr_i[7:6] == 2'b10 && adr_i[1:0] == 2'b00) begin
						buf_conf_r[adr_i[5:2]] <= {dat_i[`CBT_BTYPE_MSB:`CBT_BTYPE_LSB],
							dat_i[`CBT_ASSIGNED_BIT]};
					end
				end
				endcase
			end
			// hand one transmit request at a time to the engine
			if (!tx_pending_r && !in_init && operating_mode_r != `CBT_MODE_RX_ONLY) begin
				if (operating_mode_r == `CBT_MODE_NORMAL_ABT && block_tx_trigger_r) begin
					if (buf_ctrl_r[abt_ptr_r][`CBT_RDY_BIT] && buf_ctrl_r[abt_ptr_r][`CBT_TRQ_BIT] &&
						buf_conf_r[abt_ptr_r][3:1] == `CBT_BTYPE_TX) begin
						tx_start_o   <= 1'b1;
						tx_buf_o     <= abt_ptr_r;
						tx_pending_r <= 1'b1;
					end
					if (abt_ptr_r == `CBT_ABT_LAST_BUF) begin
						abt_ptr_r          <= 4'h0;
						block_tx_trigger_r <= 1'b0;
					end else begin
						abt_ptr_r <= abt_ptr_r + 4'h1;
					end
				end else begin
					for (i = 15; i >= 0; i = i - 1) begin
						if (buf_ctrl_r[i][`CBT_RDY_BIT] && buf_ctrl_r[i][`CBT_TRQ_BIT] &&
							buf_conf_r[i][3:1] == `CBT_BTYPE_TX && !is_rx_type(buf_conf_r[i][3:1]) &&
							!(operating_mode_r == `CBT_MODE_NORMAL_ABT && i < 8)) begin
							tx_start_o <= 1'b1;
							tx_buf_o   <= i[3:0];
							// pending rises with the start, so one request never pulses twice
							tx_pending_r <= 1'b1;
						end
					end
				end
			end
			if (tx_done_i && tx_pending_r) begin
				tx_pending_r <= 1'b0;
				buf_ctrl_r[tx_buf_o][`CBT_TRQ_BIT] <= 1'b0;
			end
		end
	end

	// busy status arrives from the protocol clock side; taken only once stages two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_sync_r <= 2'b00;
			busy_s3_r   <= 1'b0;
			busy_r      <= 1'b0;
		end else begin
			busy_sync_r <= {busy_sync_r[0], tx_busy_i};
			busy_s3_r   <= busy_sync_r[1];
			if (busy_sync_r[1] == busy_s3_r)
				busy_r <= busy_s3_r;
		end
	end

	wire transmit_status_bit = busy_r;

	// read mux and ack, one wait-free cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= 32'h0000_0000;
			if (rd) begin
				case (adr_i)
				`CBT_OFS_PRESCALER:   dat_o <= {24'h000000, prescaler_r};
				`CBT_OFS_BIT_TIMING:  dat_o <= {21'h000000, bit_timing_reg_r[10:8], 4'h0, bit_timing_reg_r[3:0]};
				`CBT_OFS_MAIN_CTRL:   dat_o <= {29'h00000000, operating_mode_r};
				`CBT_OFS_GLOBAL_CTRL: dat_o <= {31'h00000000, block_tx_trigger_r};
				`CBT_OFS_IRQ_EN:      dat_o <= {16'h0000, irq_enable_r};
				`CBT_OFS_ACC_MASK:    dat_o <= acceptance_mask_r;
				`CBT_OFS_ERR_CNT:     dat_o <= {24'h000000, error_counter_r};
				`CBT_OFS_ERR_INFO:    dat_o <= {24'h000000, error_info_r};
				`CBT_OFS_STATUS:      dat_o <= {26'h0000000, bit_len, transmit_status_bit};
				default: begin
					if (adr_i[7:6] == 2'b01 && adr_i[1:0] == 2'b00)
						dat_o <= {29'h00000000, buf_ctrl_r[adr_i[5:2]]};
					else if (adr_i[7:6] == 2'b10 && adr_i[1:0] == 2'b00)
						dat_o <= {26'h0000000, buf_conf_r[adr_i[5:2]][3:1], 2'b00, buf_conf_r[adr_i[5:2]][0]};
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/can_bit_timing_and_buffer_control_bench.sv
// Purpose: bench for cbt_top
// Assumes: ack within 50 cycles
// Notes:   prescaler 3, 16 quanta
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_and_buffer_control_bench;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, slow = 0;
	logic        ack_o, tq_tick_o, bit_tick_o, sample_pt_o, tx_start_o, tx_busy_i, tx_done_i;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF, tx_buf_o, m;
	logic [2:0]  mode_o;
	logic [31:0] dat_i = 32'h0, dat_o, q, seed = 32'hA2B8B294;
	int          error_cnt = 0, compares = 0, ndone = 0, t = 0, bit_t = 0, bit_per = 0, k, i, n;
	int          exp_q[$];
	always #5 clk_i = ~clk_i;
	cbt_top u_cbt_top (.*);
	cbt_engine_model u_cbt_engine_model (.clk_i(clk_i), .rst_i(rst_i), .tx_start_i(tx_start_o), .slow_i(slow),
		.tx_busy_o(tx_busy_i), .tx_done_o(tx_done_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude(input int lost);
		error_cnt += lost;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// request held until ack is seen high at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		for (i = 0; i < 50 && ack_o !== 1'b1; i++)
			@(posedge clk_i);
		if (ack_o !== 1'b1)
			conclude(1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// negedge polling keeps clear of the monitor's updates
	task automatic wait_done(input int n);
		for (i = 0; i < 2000 && ndone < n; i++)
			@(negedge clk_i);
		if (ndone < n)
			conclude(1);
	endtask
	always @(posedge clk_i) begin
		t++;
		ndone += tx_done_i;
		if (tx_start_o)
			chk({28'h0, tx_buf_o}, exp_q.size() ? exp_q.pop_front() : 99, "tx buffer");
		if (bit_tick_o) begin
			bit_per = t - bit_t;
			bit_t = t;
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0000_0603, "timing reset");
		wb(1'b1, 8'h00, 32'h3);
		wb(1'b1, 8'h04, 32'h0607);
		wb(1'b1, 8'h0C, 32'h2);
		wb(1'b0, 8'hFC, 32'h0);
		chk(q, 32'h0, "unmapped");
		for (k = 6; k >= 0; k--) begin
			wb(1'b1, 8'h10, 32'h0);
			wb(1'b1, 8'h08, k);
			@(posedge clk_i); // mode output trails the register by one clock
			chk({29'h0, mode_o}, (k > 5) ? 0 : k, "mode");
		end
		seed = xs(seed);
		wb(1'b1, 8'h14, seed);
		wb(1'b0, 8'h14, 32'h0);
		chk(q, seed, "mask");
		wb(1'b1, 8'h08, 32'h1);
		wb(1'b0, 8'h20, 32'h0);
		chk(q & 32'h3E, 32'h20, "quanta");
		repeat (200) @(posedge clk_i);
		chk(bit_per, 64, "bit period");
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			m = seed[3:0];
			slow <= k[0];
			wb(1'b1, {2'h2, m, 2'h0}, 32'h1);
			wb(1'b1, {2'h1, m, 2'h0}, 32'h2);
			wb(1'b0, {2'h1, m, 2'h0}, 32'h0);
			chk(q, 32'h0, "request refused");
			wb(1'b1, {2'h1, m, 2'h0}, 32'h1);
			exp_q.push_back(m);
			wb(1'b1, {2'h1, m, 2'h0}, 32'h3);
			if (k[0]) begin
				repeat (8) @(posedge clk_i);
				wb(1'b0, 8'h20, 32'h0);
				chk(q & 32'h1, 32'h1, "tx status busy");
			end
			wait_done(k + 1);
			wb(1'b1, {2'h1, m, 2'h0}, 32'h0);
		end
		// receive type never transmits, even with ready and request set
		wb(1'b1, 8'hBC, 32'h9);
		wb(1'b1, 8'h7C, 32'h1);
		wb(1'b1, 8'h7C, 32'h3);
		repeat (256) @(posedge clk_i);
		wb(1'b1, 8'h7C, 32'h0);
		wb(1'b1, 8'hBC, 32'h0);
		wb(1'b1, 8'h08, 32'h0);
		wb(1'b1, 8'h10, 32'h0);
		wb(1'b1, 8'h08, 32'h2);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q & 32'h1, 32'h0, "trigger idle");
		for (k = 0; k < 10; k++) begin
			wb(1'b1, {2'h2, k[3:0], 2'h0}, 32'h1);
			wb(1'b1, {2'h1, k[3:0], 2'h0}, 32'h1);
			if (k > 7)
				exp_q.push_back(k);
			wb(1'b1, {2'h1, k[3:0], 2'h0}, 32'h3);
		end
		wait_done(6);
		q = 32'h1;
		for (n = 0; n < 50 && q[0] !== 1'b0; n++)
			wb(1'b0, 8'h20, 32'h0);
		chk(q & 32'h1, 32'h0, "tx status");
		for (k = 0; k < 8; k++)
			exp_q.push_back(k);
		wb(1'b1, 8'h0C, 32'h1);
		wait_done(14);
		repeat (100) @(posedge clk_i);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q & 32'h1, 32'h0, "trigger");
		chk(exp_q.size(), 0, "block count");
		conclude(0);
	end
endmodule
`default_nettype wire

// ### tb/cbt_engine_model.sv
// Purpose: protocol engine stand-in
// Assumes: one frame at a time
// Notes:   slow_i stretches busy
`timescale 1ns/1ps
`default_nettype none
module cbt_engine_model (
	input  wire logic tx_start_i,
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic slow_i,
	output var  logic tx_busy_o,
	output var  logic tx_done_o
);
	logic [7:0] cnt_r = 8'h00;
	initial tx_busy_o = 1'b0;
	initial tx_done_o = 1'b0;
	always @(posedge clk_i) begin
		tx_done_o <= cnt_r == 8'h01;
		if (rst_i || cnt_r == 8'h01)
			cnt_r <= 8'h00;
		else if (tx_start_i)
			cnt_r <= slow_i ? 8'h60 : 8'h05;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
		tx_busy_o <= !rst_i && (tx_start_i || cnt_r > 8'h01);
	end
endmodule
`default_nettype wire

// ### tb/cbt_top_sva.sv
// Purpose: port checks for cbt_top
// Assumes: one clock, sync reset
// Notes:   bound by name
`timescale 1ns/1ps
`default_nettype none
module cbt_top_sva (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic       tq_tick_o,
	input wire logic       bit_tick_o,
	input wire logic       sample_pt_o,
	input wire logic       tx_start_o,
	input wire logic [2:0] mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [5:0] qcnt_r;
	logic       seen_r;
	// quanta since last bit end; cleared in init, where timing is frozen
	always @(posedge clk_i) begin
		if (rst_i || mode_o == 3'h0) begin
			qcnt_r <= 6'h00;
			seen_r <= 1'b0;
		end else if (bit_tick_o) begin
			qcnt_r <= 6'h00;
			seen_r <= 1'b1;
		end else if (tq_tick_o)
			qcnt_r <= qcnt_r + 6'h01;
	end
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	a_mode_legal: assert property (mode_o <= 3'h5) else $error("bad mode");
	a_init_frozen: assert property (mode_o == 3'h0 && $past(mode_o) == 3'h0 |-> !tq_tick_o) else $error("tq in init");
	a_bit_span: assert property (bit_tick_o && seen_r |-> qcnt_r >= 6'h07 && qcnt_r <= 6'h18) else $error("bit span");
	a_sample_late: assert property (sample_pt_o && seen_r |-> qcnt_r >= 6'h04) else $error("sample early");
	a_start_active: assert property (tx_start_o |-> mode_o != 3'h0 ##1 !tx_start_o) else $error("bad start");
	c_start: cover property (tx_start_o);
	c_bit: cover property (bit_tick_o && seen_r);
	c_sample: cover property (sample_pt_o && seen_r);
endmodule
bind cbt_top cbt_top_sva u_cbt_top_sva (.*);
`default_nettype wire
